// file: tnhr_top.v
// Host registers, I/O-mapped buffer access and transmit handshake of the node
`include "tnhr_defines.vh"
`default_nettype none
module tnhr_top (
  input wire clk_i,
  input wire arst_n_i,
  input wire [3:0] io_addr_i,
  input wire io_rd_i,
  input wire io_wr_i,
  input wire [15:0] io_wdata_i,
  output reg [15:0] io_rdata_o,
  input wire [7:0] node_switch_i,
  input wire bus16_en_i,
  input wire io_mapped_i,
  input wire long_en_i,
  input wire send_page_cmd_i,
  input wire [2:0] page_i,
  input wire cancel_cmd_i,
  output reg tx_available_flag_o,
  output reg tx_acked_flag_o,
  output reg boot_rom_select_n_o,
  output reg soft_reset_o,
  output reg tx_off_o,
  output reg ram_visible_o,
  input wire token_i,
  input wire reply_valid_i,
  input wire [1:0] reply_code_i,
  output reg query_o,
  output reg [7:0] query_dest_o,
  output reg pass_token_o,
  output wire tx_valid_o,
  input wire tx_ready_i,
  output wire [7:0] tx_data_o,
  output reg tx_last_o
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_DEST = 7'h02;
  localparam [6:0] S_TOKEN = 7'h04;
  localparam [6:0] S_QUERY = 7'h08;
  localparam [6:0] S_SEND = 7'h10;
  localparam [6:0] S_DRAIN = 7'h20;
  localparam [6:0] S_ACK = 7'h40;

  reg [6:0] state_r;
  reg [7:0] node_identity_r;
  reg rst_seen_r;
  reg ram_en_r;
  reg [7:0] ptr_lo_r;
  reg [7:0] ptr_hi_r;
  reg cancel_r;
  reg [10:0] seg_base_r;
  reg seg_long_r;
  reg [7:0] dest_r;
  reg [8:0] pos_r;
  reg rd_pend_r;
  reg [8:0] pos_pend_r;
  reg fetch_r;
  reg pkt_long_r;
  reg out_idle_r;

  wire [15:0] ram_host_rdata;
  wire [7:0] ram_tx_rdata;
  wire fifo_in_ready;
  wire fifo_out_valid;

  function is_ofs;
    input [3:0] a;
    input [3:0] ofs;
    begin
      is_ofs = (a == ofs);
    end
  endfunction

  wire acc = io_rd_i || io_wr_i;
  wire sw_rst = acc && (io_addr_i >= `TNHR_OFS_RST_LO) && (io_addr_i <= `TNHR_OFS_RST_HI);
  wire switches_zero = (node_switch_i == 8'h00);
  // Data ports only live in I/O-mapped mode and while the buffer is exposed
  wire data_ok = io_mapped_i && ram_visible_o;
  wire data_lo_acc = acc && data_ok && is_ofs(io_addr_i, `TNHR_OFS_DATA_LO);
  wire data_hi_acc = acc && data_ok && is_ofs(io_addr_i, `TNHR_OFS_DATA_HI);
  wire wide = bus16_en_i && data_lo_acc;
  wire [10:0] ptr = {ptr_hi_r[2:0], ptr_lo_r};
  wire [10:0] host_addr = wide ? {ptr[10:1], 1'b0} : ptr;
  wire we_lo = io_wr_i && (wide || ((data_lo_acc || data_hi_acc) && !ptr[0]));
  wire we_hi = io_wr_i && (wide || ((data_lo_acc || data_hi_acc) && ptr[0]));
  wire [15:0] host_wdata = wide ? io_wdata_i : {io_wdata_i[7:0], io_wdata_i[7:0]};
  wire [10:0] ptr_step = wide ? 11'h002 : 11'h001;
  wire [10:0] ptr_inc = ptr + ptr_step;

  // Transmit side: one outstanding buffer read at a time keeps the FIFO from overrunning
  wire [8:0] seg_last = pkt_long_r ? 9'h1FF : 9'h0FF;
  wire tx_on = (node_identity_r != 8'h00);
  wire [10:0] tx_addr = seg_base_r + {2'b00, fetch_r ? 9'h001 : pos_r};
  wire issue = (state_r == S_SEND) && !rd_pend_r && fifo_in_ready;
  wire [7:0] push_byte = (pos_pend_r == 9'h000) ? node_identity_r : ram_tx_rdata;
  wire push = rd_pend_r;
  wire push_last = rd_pend_r && (pos_pend_r == seg_last);
  reg [8:0] pos_nxt;

  always @* begin
    pos_nxt = pos_pend_r + 9'h001;
    if (pos_pend_r == 9'h002) begin
      if (seg_long_r && (ram_tx_rdata == 8'h00)) begin
        pos_nxt = 9'h003;
      end else begin
        pos_nxt = {1'b0, ram_tx_rdata};
      end
    end else if (pos_pend_r == 9'h003 && pkt_long_r) begin
      // Long count sits in byte 3; data runs from 512 minus length to the end
      pos_nxt = {1'b0, ram_tx_rdata};
    end
  end

  tnhr_ram u_ram (
    .clk_i(clk_i),
    .host_addr_i(host_addr),
    .host_we_lo_i(we_lo),
    .host_we_hi_i(we_hi),
    .host_wdata_i(host_wdata),
    .host_rdata_o(ram_host_rdata),
    .tx_addr_i(tx_addr),
    .tx_rdata_o(ram_tx_rdata)
  );

  tnhr_fifo #(
    .WIDTH(`TNHR_FIFO_WIDTH),
    .DEPTH(`TNHR_FIFO_DEPTH),
    .AW(`TNHR_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .flush_i(soft_reset_o),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_byte),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(tx_ready_i),
    .out_data_o(tx_data_o)
  );
  assign tx_valid_o = fifo_out_valid;

  // Identity register, RAM exposure and register strobes
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      node_identity_r <= `TNHR_NODE_IDENTITY_RST;
      rst_seen_r <= 1'b0;
      ram_en_r <= 1'b0;
      boot_rom_select_n_o <= 1'b1;
      soft_reset_o <= 1'b0;
      tx_off_o <= 1'b1;
      ram_visible_o <= 1'b0;
      io_rdata_o <= 16'h0000;
    end else begin
      soft_reset_o <= sw_rst;
      boot_rom_select_n_o <= !(io_wr_i && is_ofs(io_addr_i, `TNHR_OFS_EXT));
      if (sw_rst) begin
        rst_seen_r <= 1'b1;
      end
      if (!switches_zero) begin
        node_identity_r <= node_switch_i;
      end else if (io_wr_i && is_ofs(io_addr_i, `TNHR_OFS_NODE_IDENTITY)) begin
        node_identity_r <= io_wdata_i[7:0];
        if (rst_seen_r && (io_wdata_i[7:0] != 8'h00)) begin
          ram_en_r <= 1'b1;
        end
      end
      tx_off_o <= (node_identity_r == 8'h00);
      ram_visible_o <= !switches_zero || ram_en_r;
      if (io_rd_i) begin
        if (is_ofs(io_addr_i, `TNHR_OFS_NODE_IDENTITY)) begin
          io_rdata_o <= {8'h00, node_identity_r};
        end else if (data_lo_acc || data_hi_acc) begin
          if (wide) begin
            io_rdata_o <= ram_host_rdata;
          end else begin
            io_rdata_o <= {8'h00, ptr[0] ? ram_host_rdata[15:8] : ram_host_rdata[7:0]};
          end
        end else if (is_ofs(io_addr_i, `TNHR_OFS_PTR_LO)) begin
          io_rdata_o <= {8'h00, ptr_lo_r};
        end else if (is_ofs(io_addr_i, `TNHR_OFS_PTR_HI)) begin
          io_rdata_o <= {8'h00, ptr_hi_r};
        end else begin
          io_rdata_o <= 16'h0000;
        end
      end
    end
  end

  // Pointer has no reset: its contents are undefined after any reset
  always @(posedge clk_i) begin
    if (io_wr_i && is_ofs(io_addr_i, `TNHR_OFS_PTR_LO)) begin
      ptr_lo_r <= io_wdata_i[7:0];
    end else if (io_wr_i && is_ofs(io_addr_i, `TNHR_OFS_PTR_HI)) begin
      ptr_hi_r <= io_wdata_i[7:0];
    end else if ((data_lo_acc || data_hi_acc) && ptr_hi_r[`TNHR_PTRH_AUTOINC]) begin
      ptr_lo_r <= ptr_inc[7:0];
      ptr_hi_r <= {ptr_hi_r[7:3], ptr_inc[10:8]};
    end
  end

  // Transmit handshake
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= S_IDLE;
      tx_available_flag_o <= 1'b1;
      tx_acked_flag_o <= 1'b0;
      cancel_r <= 1'b0;
      seg_base_r <= 11'h000;
      seg_long_r <= 1'b0;
      dest_r <= 8'h00;
      pos_r <= 9'h000;
      rd_pend_r <= 1'b0;
      pos_pend_r <= 9'h000;
      fetch_r <= 1'b0;
      pkt_long_r <= 1'b0;
      out_idle_r <= 1'b0;
      query_o <= 1'b0;
      query_dest_o <= 8'h00;
      pass_token_o <= 1'b0;
      tx_last_o <= 1'b0;
    end else if (soft_reset_o) begin
      // Soft reset drops any pending send and leaves the transmitter free
      state_r <= S_IDLE;
      tx_available_flag_o <= 1'b1;
      tx_acked_flag_o <= 1'b0;
      cancel_r <= 1'b0;
      rd_pend_r <= 1'b0;
      fetch_r <= 1'b0;
      query_o <= 1'b0;
      pass_token_o <= 1'b0;
      tx_last_o <= 1'b0;
    end else begin
      query_o <= 1'b0;
      pass_token_o <= 1'b0;
      rd_pend_r <= issue;
      // Output low two cycles running with no push means the FIFO is empty
      out_idle_r <= !fifo_out_valid && !push;
      if (issue) begin
        pos_pend_r <= pos_r;
      end
      if (push) begin
        tx_last_o <= push_last;
        if (pos_pend_r == 9'h002) begin
          pkt_long_r <= seg_long_r && (ram_tx_rdata == 8'h00);
        end
      end
      if (cancel_cmd_i && (state_r != S_IDLE)) begin
        cancel_r <= 1'b1;
      end
      case (state_r)
        S_IDLE: begin
          if (send_page_cmd_i) begin
            tx_available_flag_o <= 1'b0;
            tx_acked_flag_o <= 1'b0;
            seg_long_r <= long_en_i;
            seg_base_r <= long_en_i ? {page_i[1:0], 9'h000} : {page_i, 8'h00};
            cancel_r <= 1'b0;
            fetch_r <= 1'b1;
            state_r <= S_DEST;
          end
        end
        S_DEST: begin
          fetch_r <= 1'b0;
          if (!fetch_r) begin
            dest_r <= ram_tx_rdata;
            state_r <= S_TOKEN;
          end
        end
        S_TOKEN: begin
          // Transmitter off: the token is neither used nor passed
          if (token_i && tx_on) begin
            if (cancel_r) begin
              tx_available_flag_o <= 1'b1;
              cancel_r <= 1'b0;
              pass_token_o <= 1'b1;
              state_r <= S_IDLE;
            end else if (dest_r == 8'h00) begin
              pos_r <= 9'h000;
              state_r <= S_SEND;
            end else begin
              query_o <= 1'b1;
              query_dest_o <= dest_r;
              state_r <= S_QUERY;
            end
          end
        end
        S_QUERY: begin
          if (reply_valid_i) begin
            case (reply_code_i)
              `TNHR_REPLY_ACK: begin
                pos_r <= 9'h000;
                state_r <= S_SEND;
              end
              `TNHR_REPLY_NAK: begin
                pass_token_o <= 1'b1;
                state_r <= S_TOKEN;
              end
              `TNHR_REPLY_NONE: begin
                tx_available_flag_o <= 1'b1;
                pass_token_o <= 1'b1;
                state_r <= S_IDLE;
              end
              default: begin
                state_r <= S_TOKEN;
              end
            endcase
          end
        end
        S_SEND: begin
          if (push) begin
            if (push_last) begin
              state_r <= S_DRAIN;
            end else begin
              pos_r <= pos_nxt;
            end
          end
        end
        S_DRAIN: begin
          if (!fifo_out_valid && out_idle_r && !rd_pend_r) begin
            state_r <= S_ACK;
          end
        end
        S_ACK: begin
          if (reply_valid_i) begin
            tx_available_flag_o <= 1'b1;
            tx_acked_flag_o <= (reply_code_i == `TNHR_REPLY_ACK) && (dest_r != 8'h00);
            pass_token_o <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
      // Identity cleared mid-send: query and token pass stop at once, but packet bytes keep flowing
      if (!tx_on) begin
        query_o <= 1'b0;
        pass_token_o <= 1'b0;
      end
    end
  end
endmodule // tnhr_top
`default_nettype wire

// file: tnhr_defines.vh
// Constants for the node host registers and transmit control
// Contract
// - Identity readable always; writable only while the identity switches read zero.
// - Zero identity keeps the transmitter off: no token passing, no joining.
// - Node stays out of the network until a nonzero identity is written.
// - Zero switches hide buffer RAM; soft reset then valid identity write exposes it.
// - Identity register at offset five, cleared by hardware reset only.
// - Write to offset seven pulses the boot ROM select; reads there return junk.
// - Any access to offsets eight through eleven performs a software reset.
// - Data ports reach the buffer at the pointer, in I/O-mapped mode only.
// - Pointer may auto-advance; pointer and data port are undefined after reset.
// - With a 16-bit bus the buffer appears as 1K words of 16 bits.
// - Byte 1 destination; byte 2 nonzero short count, zero means long, byte 3 count.
// - Device writes its own identity as byte 0 on transmission.
// - Host waits for transmitter available; device sets it when a send concludes.
// - Send-page command clears transmitter available and acknowledged flags.
// - Non-broadcast send first queries the destination for a free buffer.
// - Positive reply sends packet; acknowledged sets both flags, else acked stays zero.
// - Negative reply passes the token and retries the query at next token.
// - No reply sets transmitter available, leaves acknowledged at zero.
// - Unrecognised reply: token is not passed.
// - Cancel abandons pending send at next token; available set, acknowledged zero.
// - Pointer high bit 6 set advances the pointer after each data port access.
// - Pointer high bits 2-0 hold address bits 10-8; low register bits 7-0.
`ifndef TNHR_DEFINES_VH
`define TNHR_DEFINES_VH
`define TNHR_OFS_NODE_IDENTITY 4'h5
`define TNHR_OFS_EXT 4'h7
`define TNHR_OFS_RST_LO 4'h8
`define TNHR_OFS_RST_HI 4'hB
`define TNHR_OFS_DATA_LO 4'hC
`define TNHR_OFS_DATA_HI 4'hD
`define TNHR_OFS_PTR_LO 4'hE
`define TNHR_OFS_PTR_HI 4'hF
`define TNHR_NODE_IDENTITY_RST 8'h00
`define TNHR_PTRH_AUTOINC 6
`define TNHR_REPLY_ACK 2'h0
`define TNHR_REPLY_NAK 2'h1
`define TNHR_REPLY_NONE 2'h2
`define TNHR_REPLY_OTHER 2'h3
`define TNHR_FIFO_WIDTH 8
`define TNHR_FIFO_DEPTH 8
`define TNHR_FIFO_AW 3
`endif

// file: tnhr_fifo.v
// Transmit byte FIFO with a registered output stage
`default_nettype none
module tnhr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output reg out_valid_o,
  input wire out_ready_i,
  output reg [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = (count_r != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);
  assign in_ready_o = (count_r != DEPTH[AW:0]);
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end else if (flush_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
        out_data_o <= mem[rd_ptr_r];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // tnhr_fifo
`default_nettype wire

// file: tnhr_ram.v
// 2K x 8 packet buffer as even and odd banks, host word port and transmit byte port
`default_nettype none
module tnhr_ram (
  input wire clk_i,
  input wire [10:0] host_addr_i,
  input wire host_we_lo_i,
  input wire host_we_hi_i,
  input wire [15:0] host_wdata_i,
  output reg [15:0] host_rdata_o,
  input wire [10:0] tx_addr_i,
  output reg [7:0] tx_rdata_o
);
  reg [7:0] bank_even [0:1023];
  reg [7:0] bank_odd [0:1023];
  always @(posedge clk_i) begin
    if (host_we_lo_i) begin
      bank_even[host_addr_i[10:1]] <= host_wdata_i[7:0];
    end
    if (host_we_hi_i) begin
      bank_odd[host_addr_i[10:1]] <= host_wdata_i[15:8];
    end
    host_rdata_o <= {bank_odd[host_addr_i[10:1]], bank_even[host_addr_i[10:1]]};
    tx_rdata_o <= tx_addr_i[0] ? bank_odd[tx_addr_i[10:1]] : bank_even[tx_addr_i[10:1]];
  end
endmodule // tnhr_ram
`default_nettype wire

// file: tnhr_assertions.sv
// Port-level checker for the node host registers and transmit control
`default_nettype none
`include "tnhr_defines.vh"
module tnhr_assertions (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic send_page_cmd_i,
  input wire logic token_i,
  input wire logic reply_valid_i,
  input wire logic [1:0] reply_code_i,
  input wire logic tx_available_flag_o,
  input wire logic tx_acked_flag_o,
  input wire logic boot_rom_select_n_o,
  input wire logic soft_reset_o,
  input wire logic tx_off_o,
  input wire logic query_o,
  input wire logic pass_token_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic rst_hit;
  logic ext_wr;
  assign rst_hit = (io_rd_i || io_wr_i) && io_addr_i >= `TNHR_OFS_RST_LO && io_addr_i <= `TNHR_OFS_RST_HI;
  assign ext_wr = io_wr_i && io_addr_i == `TNHR_OFS_EXT;
  sequence s_rom_pulse;
    !boot_rom_select_n_o ##1 boot_rom_select_n_o;
  endsequence
  sequence s_flags_low;
    !tx_available_flag_o && !tx_acked_flag_o;
  endsequence
  a_rom_sel_pulse: assert property (ext_wr ##1 !ext_wr |-> s_rom_pulse) else $error("rom select pulse wrong");
  a_rom_sel_cause: assert property (!boot_rom_select_n_o |-> $past(ext_wr)) else $error("rom select w/o write");
  a_soft_rst_hit: assert property (rst_hit |=> soft_reset_o) else $error("no soft reset");
  a_send_clears: assert property (send_page_cmd_i && tx_available_flag_o && !soft_reset_o |=> s_flags_low)
    else $error("flags not cleared");
  a_txoff_quiet: assert property (tx_off_o |-> !query_o && !pass_token_o) else $error("tx while off");
  a_query_token: assert property (query_o |-> $past(token_i)) else $error("query w/o token");
  a_acked_with_ta: assert property (tx_acked_flag_o |-> tx_available_flag_o) else $error("acked w/o available");
  a_ta_rise_cause: assert property ($rose(tx_available_flag_o) |-> $past(reply_valid_i || token_i || soft_reset_o))
    else $error("available rose w/o cause");
  a_other_no_pass: assert property (reply_valid_i && reply_code_i == `TNHR_REPLY_OTHER |=> !pass_token_o)
    else $error("token passed on junk reply");
endmodule // tnhr_assertions
bind tnhr_top tnhr_assertions tnhr_assertions_i (.clk_i, .arst_n_i, .io_addr_i, .io_rd_i, .io_wr_i, .send_page_cmd_i,
  .token_i, .reply_valid_i, .reply_code_i, .tx_available_flag_o, .tx_acked_flag_o, .boot_rom_select_n_o,
  .soft_reset_o, .tx_off_o, .query_o, .pass_token_o);
`default_nettype wire

// file: tnhr_net_model.sv
// Network-side model: token and reply source, stalling packet byte sink
`default_nettype none
module tnhr_net_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output var logic tx_ready_o,
  output var logic token_o,
  output var logic reply_valid_o,
  output var logic [1:0] reply_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  initial begin
    tx_ready_o = 1'b0;
    token_o = 1'b0;
    reply_valid_o = 1'b0;
    reply_code_o = 2'h0;
  end
  // Stall every other cycle so the FIFO backs up
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_ready_o <= 1'b0;
      got.delete();
    end else begin
      tx_ready_o <= !tx_ready_o;
      if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    end
  end
  task token();
    @(posedge clk_i) token_o <= 1'b1;
    @(posedge clk_i) token_o <= 1'b0;
  endtask
  task reply(input logic [1:0] c);
    @(posedge clk_i) begin
      reply_valid_o <= 1'b1;
      reply_code_o <= c;
    end
    @(posedge clk_i) begin
      reply_valid_o <= 1'b0;
      reply_code_o <= ~c;
    end
  endtask
endmodule // tnhr_net_model
`default_nettype wire

// file: test_tnhr_top.sv
// Testbench: host register access and transmit handshake of the node
`default_nettype none
`include "tnhr_defines.vh"
module test_tnhr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] io_addr_i = 4'h0;
  logic io_rd_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic [15:0] io_wdata_i = 16'h0000;
  logic send_page_cmd_i = 1'b0;
  logic cancel_cmd_i = 1'b0;
  logic [2:0] page_i = 3'h0;
  logic [7:0] node_switch_i = 8'h00;
  logic bus16_en_i = 1'b0;
  logic io_mapped_i = 1'b1;
  wire [15:0] io_rdata_o;
  wire ta, tx_acked_flag, rom_n, srst, txoff, vis, tok, rv, qry, pass, tv, trdy, tlast;
  wire [1:0] rc;
  wire [7:0] qdest, tdata;
  logic [15:0] d;
  logic [7:0] exp_b[6] = '{8'h2A, 8'h33, 8'hFD, 8'h11, 8'h22, 8'h33};
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  always #12.5 clk_i = ~clk_i;
  tnhr_top tnhr_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .node_switch_i(node_switch_i),
    .bus16_en_i(bus16_en_i), .io_mapped_i(io_mapped_i), .long_en_i(1'b0), .send_page_cmd_i(send_page_cmd_i),
    .page_i(page_i), .cancel_cmd_i(cancel_cmd_i), .tx_available_flag_o(ta), .tx_acked_flag_o(tx_acked_flag),
    .boot_rom_select_n_o(rom_n), .soft_reset_o(srst), .tx_off_o(txoff), .ram_visible_o(vis), .token_i(tok),
    .reply_valid_i(rv), .reply_code_i(rc), .query_o(qry), .query_dest_o(qdest), .pass_token_o(pass),
    .tx_valid_o(tv), .tx_ready_i(trdy), .tx_data_o(tdata), .tx_last_o(tlast));
  tnhr_net_model tnhr_net_model_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .tx_valid_i(tv), .tx_data_i(tdata),
    .tx_ready_o(trdy), .token_o(tok), .reply_valid_o(rv), .reply_code_o(rc));
  task close_out();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i) begin
      io_addr_i <= a;
      io_wdata_i <= v;
      io_wr_i <= 1'b1;
    end
    @(posedge clk_i) io_wr_i <= 1'b0;
    @(negedge clk_i);
  endtask
  // Two idle cycles first: buffer read is registered behind the pointer
  task rd(input logic [3:0] a);
    repeat (2) @(posedge clk_i);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge clk_i) io_rd_i <= 1'b0;
    @(negedge clk_i) d = io_rdata_o;
  endtask
  task wait_ta();
    for (int i = 0; i < 40 && ta !== 1'b1; i++) @(negedge clk_i);
  endtask
  task send();
    wait_ta();
    @(posedge clk_i) begin
      send_page_cmd_i <= 1'b1;
      page_i <= 3'h1;
    end
    @(posedge clk_i) send_page_cmd_i <= 1'b0;
    @(negedge clk_i);
    chk(ta, 1'b0);
    chk(tx_acked_flag, 1'b0);
    // Destination fetch must finish before a token counts
    repeat (2) @(negedge clk_i);
  endtask
  task ask(input logic [1:0] c);
    tnhr_net_model_i.token();
    for (int i = 0; i < 10 && qry !== 1'b1; i++) @(negedge clk_i);
    chk(qry, 1'b1);
    chk(qdest, 8'h33);
    tnhr_net_model_i.reply(c);
    @(negedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk({ta, tx_acked_flag, rom_n, txoff}, 4'hB);
    tnhr_net_model_i.token();
    rd(`TNHR_OFS_NODE_IDENTITY);
    chk(d[7:0], `TNHR_NODE_IDENTITY_RST);
    for (int a = 8; a <= 11; a++) begin
      if (a[0]) wr(a[3:0], 16'h0000);
      else rd(a[3:0]);
      chk(srst, 1'b1);
    end
    wr(`TNHR_OFS_NODE_IDENTITY, 16'h002A);
    rd(`TNHR_OFS_NODE_IDENTITY);
    chk(d[7:0], 8'h2A);
    repeat (2) @(negedge clk_i);
    chk(txoff, 1'b0);
    chk(vis, 1'b1);
    wr(`TNHR_OFS_EXT, 16'h005A);
    chk(rom_n, 1'b0);
    // Page 1 short packet: 3 data bytes, count offset 256-3
    wr(`TNHR_OFS_PTR_HI, 16'h0041);
    wr(`TNHR_OFS_PTR_LO, 16'h0001);
    wr(`TNHR_OFS_DATA_LO, 16'h0033);
    wr(`TNHR_OFS_DATA_LO, 16'h00FD);
    wr(`TNHR_OFS_PTR_LO, 16'h00FD);
    for (int i = 3; i < 6; i++) wr(`TNHR_OFS_DATA_LO, {8'h00, exp_b[i]});
    rd(`TNHR_OFS_PTR_HI);
    chk(d[7:0], 8'h42);
    wr(`TNHR_OFS_PTR_HI, 16'h0041);
    wr(`TNHR_OFS_PTR_LO, 16'h0001);
    for (int i = 1; i < 3; i++) begin
      rd(`TNHR_OFS_DATA_LO);
      chk(d[7:0], exp_b[i]);
    end
    send();
    ask(`TNHR_REPLY_NAK);
    chk(pass, 1'b1);
    chk(ta, 1'b0);
    ask(`TNHR_REPLY_ACK);
    chk(tlast, 1'b0);
    for (int i = 0; i < 200 && tnhr_net_model_i.got.size() < 6; i++) @(negedge clk_i);
    chk(tnhr_net_model_i.got.size(), 16'd6);
    for (int i = 0; i < 6 && i < tnhr_net_model_i.got.size(); i++) chk(tnhr_net_model_i.got[i], exp_b[i]);
    chk(tlast, 1'b1);
    // Packet reply only once the node has seen its FIFO drain
    repeat (2) @(negedge clk_i);
    tnhr_net_model_i.reply(`TNHR_REPLY_ACK);
    wait_ta();
    chk({ta, tx_acked_flag}, 2'h3);
    send();
    ask(`TNHR_REPLY_NONE);
    wait_ta();
    chk({ta, tx_acked_flag}, 2'h2);
    send();
    ask(`TNHR_REPLY_OTHER);
    chk(pass, 1'b0);
    @(posedge clk_i) cancel_cmd_i <= 1'b1;
    @(posedge clk_i) cancel_cmd_i <= 1'b0;
    @(negedge clk_i);
    chk(ta, 1'b0);
    tnhr_net_model_i.token();
    wait_ta();
    chk({ta, tx_acked_flag}, 2'h2);
    // Word access on the wide bus, then the data port outside I/O-mapped mode
    @(posedge clk_i) bus16_en_i <= 1'b1;
    wr(`TNHR_OFS_PTR_HI, 16'h0041);
    wr(`TNHR_OFS_PTR_LO, 16'h0010);
    wr(`TNHR_OFS_DATA_LO, 16'hBEEF);
    rd(`TNHR_OFS_PTR_LO);
    chk(d[7:0], 8'h12);
    @(posedge clk_i) io_mapped_i <= 1'b0;
    wr(`TNHR_OFS_DATA_LO, 16'h1234);
    @(posedge clk_i) io_mapped_i <= 1'b1;
    wr(`TNHR_OFS_PTR_LO, 16'h0010);
    rd(`TNHR_OFS_DATA_LO);
    chk(d, 16'hBEEF);
    // Nonzero switches own the identity; host writes are ignored
    @(posedge clk_i) node_switch_i <= 8'h07;
    wr(`TNHR_OFS_NODE_IDENTITY, 16'h0055);
    rd(`TNHR_OFS_NODE_IDENTITY);
    chk(d[7:0], 8'h07);
    close_out();
  end
endmodule // test_tnhr_top
`default_nettype wire
